// File: rtl/data_memory_sector_decoder_regs.svh
// Address map constants for the data memory sector decoder
`ifndef DATA_MEMORY_SECTOR_DECODER_REGS_SVH
`define DATA_MEMORY_SECTOR_DECODER_REGS_SVH
`define OFS_INDIRECT_PORT_ZERO 8'h00
`define OFS_POINTER_ZERO 8'h01
`define OFS_INDIRECT_PORT_ONE 8'h02
`define OFS_POINTER_ONE_OFFSET 8'h03
`define OFS_POINTER_ONE_SECTOR 8'h04
`define OFS_INDIRECT_PORT_TWO 8'h0c
`define OFS_POINTER_TWO_OFFSET 8'h0d
`define OFS_POINTER_TWO_SECTOR 8'h0e
`define OFS_NONVOLATILE_CONTROL 8'h40
`define SFR_LIMIT 8'h80
`define GP_BASE 8'h80
`define DISPLAY_LIMIT 8'h20
`define SECTOR_SFR 3'h0
`define SECTOR_NV 3'h1
`define SECTOR_GP_LAST 3'h2
`define SECTOR_DISPLAY 3'h4
`define POINTER_RESET 8'h00
`define READ_UNUSED 8'h00
`endif

// File: rtl/data_memory_sector_decoder_pkg.sv
// Types shared by the data memory sector decoder files
package data_memory_sector_decoder_pkg;
   typedef enum logic [1:0] {
      target_none_type_v = 2'b00,
      target_sfr_v = 2'b01,
      target_gp_v = 2'b11,
      target_display_v = 2'b10
   } target_type;
   typedef enum logic [1:0] {
      op_write_v = 2'b00,
      op_set_v = 2'b01,
      op_clear_v = 2'b11
   } op_type;
endpackage : data_memory_sector_decoder_pkg

// File: rtl/resolve_if.sv
// Resolved address carried from the decoder core to the storage module
`timescale 1ns/1ps
`default_nettype none
interface resolve_if;
   logic wr;
   logic [1:0] op;
   logic [2:0] bit_sel;
   logic [8:0] gp_index;
   logic gp_hit;
   logic [7:0] wdata;
   logic [7:0] gp_rdata;
   modport core (output wr, output op, output bit_sel, output gp_index, output gp_hit,
      output wdata, input gp_rdata);
   modport store (input wr, input op, input bit_sel, input gp_index, input gp_hit,
      input wdata, output gp_rdata);
endinterface : resolve_if
`default_nettype wire

// File: rtl/general_purpose_store.sv
// General purpose RAM: 384 bytes as flip-flops with bit set and clear
`timescale 1ns/1ps
`default_nettype none
module general_purpose_store #(
   parameter int DEPTH = 384
) (
   input wire logic clock,
   input wire logic rst,
   resolve_if.store res
);
   import data_memory_sector_decoder_pkg::*;
   logic [7:0] mem_q [DEPTH];
   logic [7:0] mem_d [DEPTH];
   logic [7:0] cur;

   // Read is combinational so a read-modify-write completes in one cycle
   always_comb begin
      cur = mem_q[res.gp_index];
      res.gp_rdata = res.gp_hit ? cur : 8'h00;
   end

   // Next-state: full byte write, or single bit set or clear
   always_comb begin
      mem_d = mem_q;
      if (res.wr && res.gp_hit) begin
         case (op_type'(res.op))
            op_write_v: mem_d[res.gp_index] = res.wdata;
            op_set_v: mem_d[res.gp_index] = cur | (8'h01 << res.bit_sel);
            op_clear_v: mem_d[res.gp_index] = cur & ~(8'h01 << res.bit_sel);
            default: mem_d[res.gp_index] = cur;
         endcase
      end
   end

   // Contents are volatile; cleared at reset for deterministic simulation
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= 8'h00;
         end
      end else begin
         mem_q <= mem_d;
      end
   end
endmodule : general_purpose_store
`default_nettype wire

// File: rtl/data_memory_sector_decoder.sv
// Data memory sector decoder: direct, extended and indirect access resolution
// What this block does
// - Data memory is byte wide, full byte access
// - Special registers in sector 0, nonvolatile control sector 1
// - Address space starts at 00H, sector from pointers
// - 32-byte display memory at sector 4, forwarded out
// - 384 general bytes at 80H-FFH, sectors 0-2
// - Ports one and two: sector high, offset low
// - 11-bit extended direct address: sector and offset
// - Unused locations read 00H, writes discarded
// - Read-only special registers ignore core writes
// - Single bit set and clear on general bytes
// - Indirect port access acts on pointed location
// - Port zero confined to sector 0, 8-bit pointer
// - Ports one and two reach every sector
// - Port as resolved target reads 00H, no write
`timescale 1ns/1ps
`default_nettype none
`include "data_memory_sector_decoder_regs.svh"
module data_memory_sector_decoder #(
   parameter int GP_DEPTH = 384,
   parameter int DISPLAY_DEPTH = 32
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic access,
   input wire logic write,
   input wire logic extended,
   input wire logic [10:0] address,
   input wire data_memory_sector_decoder_pkg::op_type op,
   input wire logic [2:0] bit_sel,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic sfr_select,
   output logic sfr_write,
   output logic [7:0] sfr_offset,
   output logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_read_only,
   output logic nonvolatile_control_select,
   input wire logic [7:0] nonvolatile_control_register,
   output logic display_write,
   output logic [4:0] display_index,
   output logic [7:0] display_data
);
   import data_memory_sector_decoder_pkg::*;

   // Bundle toward the storage module; the store answers in the same cycle
   resolve_if res ();

   // Pointer pairs: offset low, sector high; sector bits [2:0] decode, any upper bit set lands nowhere
   logic [7:0] pointer_zero_q, pointer_zero_d;
   logic [7:0] pointer_one_offset_q, pointer_one_offset_d;
   logic [7:0] pointer_one_sector_q, pointer_one_sector_d;
   logic [7:0] pointer_two_offset_q, pointer_two_offset_d;
   logic [7:0] pointer_two_sector_q, pointer_two_sector_d;
   // Display copy kept here so reads of sector 4 return what the driver was sent
   logic [7:0] display_q [DISPLAY_DEPTH];
   logic [7:0] display_d [DISPLAY_DEPTH];
   logic display_write_q, display_write_d;
   logic [4:0] display_index_q, display_index_d;
   logic [7:0] display_data_q, display_data_d;

   // Address resolution, all combinational within the access cycle
   logic [2:0] raw_sector;
   logic [7:0] raw_offset;
   logic [2:0] eff_sector;
   logic [7:0] eff_offset;
   logic via_port;
   target_type target;
   logic [7:0] old_byte;
   logic [7:0] new_byte;
   logic pointer_hit;
   logic [7:0] pointer_value;

   // True when a sector 0 offset names one of the three indirect ports
   function automatic logic is_port(input logic [2:0] sec, input logic [7:0] ofs);
      is_port = (sec == `SECTOR_SFR) && (ofs == `OFS_INDIRECT_PORT_ZERO ||
         ofs == `OFS_INDIRECT_PORT_ONE || ofs == `OFS_INDIRECT_PORT_TWO);
   endfunction : is_port

   // Applies write, set or clear to a byte; every path yields a full byte
   function automatic logic [7:0] modify(input logic [7:0] cur, input op_type o,
      input logic [2:0] b, input logic [7:0] d);
      case (o)
         op_set_v: modify = cur | (8'h01 << b);
         op_clear_v: modify = cur & ~(8'h01 << b);
         default: modify = d;
      endcase
   endfunction : modify

   // Raw address: standard instructions are sector 0, extended ones carry the sector
   always_comb begin
      raw_sector = extended ? address[10:8] : `SECTOR_SFR;
      raw_offset = address[7:0];
   end

   // Indirect port redirection through its paired pointer
   // Only one level of redirection: a pointer that names a port lands on the
   // port's own address, which holds nothing, so chains can never loop
   always_comb begin
      via_port = is_port(raw_sector, raw_offset);
      eff_sector = raw_sector;
      eff_offset = raw_offset;
      if (via_port) begin
         case (raw_offset)
            `OFS_INDIRECT_PORT_ZERO: begin
               eff_sector = `SECTOR_SFR;
               eff_offset = pointer_zero_q;
            end
            `OFS_INDIRECT_PORT_ONE: begin
               eff_sector = pointer_one_sector_q[2:0];
               eff_offset = pointer_one_offset_q;
            end
            default: begin
               eff_sector = pointer_two_sector_q[2:0];
               eff_offset = pointer_two_offset_q;
            end
         endcase
         // Upper sector bits beyond the decoded range land nowhere
         // Wrapping them onto sectors 0-7 would alias unrelated memory
         if (raw_offset != `OFS_INDIRECT_PORT_ZERO &&
               ((raw_offset == `OFS_INDIRECT_PORT_ONE ? pointer_one_sector_q[7:3] :
               pointer_two_sector_q[7:3]) != 5'h00)) begin
            eff_sector = 3'h7;
         end
      end
   end

   // Classify the resolved location
   // Storage ranges are tried first, then the two exclusions override them
   always_comb begin
      target = target_none_type_v;
      if (eff_offset >= `GP_BASE && eff_sector <= `SECTOR_GP_LAST) begin
         target = target_gp_v;
      end else if (eff_sector == `SECTOR_DISPLAY && eff_offset < `DISPLAY_LIMIT) begin
         target = target_display_v;
      end else if (eff_offset < `SFR_LIMIT && (eff_sector == `SECTOR_SFR ||
            (eff_sector == `SECTOR_NV && eff_offset == `OFS_NONVOLATILE_CONTROL))) begin
         target = target_sfr_v;
      end
      // A port reached through a pointer has no storage of its own
      if (is_port(eff_sector, eff_offset)) begin
         target = target_none_type_v;
      end
      // Nonvolatile control only answers in sector 1
      if (eff_sector == `SECTOR_SFR && eff_offset == `OFS_NONVOLATILE_CONTROL) begin
         target = target_none_type_v;
      end
   end

   // Pointer registers are decoded here because the redirection depends on them
   // They never reach the peripheral strobes, so a peripheral cannot shadow them
   always_comb begin
      pointer_hit = 1'b0;
      pointer_value = 8'h00;
      if (target == target_sfr_v && eff_sector == `SECTOR_SFR) begin
         pointer_hit = 1'b1;
         case (eff_offset)
            `OFS_POINTER_ZERO: pointer_value = pointer_zero_q;
            `OFS_POINTER_ONE_OFFSET: pointer_value = pointer_one_offset_q;
            `OFS_POINTER_ONE_SECTOR: pointer_value = pointer_one_sector_q;
            `OFS_POINTER_TWO_OFFSET: pointer_value = pointer_two_offset_q;
            `OFS_POINTER_TWO_SECTOR: pointer_value = pointer_two_sector_q;
            default: pointer_hit = 1'b0;
         endcase
      end
   end

   // Drive the general purpose store
   // Write enable goes out unqualified; the store gates it with its own hit
   always_comb begin
      res.wr = access && write;
      res.op = op;
      res.bit_sel = bit_sel;
      res.wdata = wdata;
      res.gp_hit = (target == target_gp_v);
      res.gp_index = 9'({eff_sector[1:0], eff_offset[6:0]});
   end

   // Read data: unused and unmapped locations return 00H
   // Kept combinational so a bit set or clear can read, modify and write back
   // within the single access cycle; the cost is a long path into rdata
   always_comb begin
      old_byte = `READ_UNUSED;
      case (target)
         target_gp_v: old_byte = res.gp_rdata;
         target_display_v: old_byte = display_q[eff_offset[4:0]];
         target_sfr_v: begin
            if (pointer_hit) begin
               old_byte = pointer_value;
            end else if (eff_sector == `SECTOR_NV) begin
               old_byte = nonvolatile_control_register;
            end else begin
               old_byte = sfr_rdata;
            end
         end
         default: old_byte = `READ_UNUSED;
      endcase
      rdata = access ? old_byte : 8'h00;
      new_byte = modify(old_byte, op, bit_sel, wdata);
   end

   // Peripheral register strobes; read-only registers get no write strobe
   // Nonvolatile control shares the write strobe and data with the others
   always_comb begin
      sfr_select = access && target == target_sfr_v && !pointer_hit &&
         eff_sector == `SECTOR_SFR;
      nonvolatile_control_select = access && target == target_sfr_v &&
         eff_sector == `SECTOR_NV;
      sfr_write = access && write && target == target_sfr_v && !pointer_hit &&
         !sfr_read_only;
      sfr_offset = eff_offset;
      sfr_wdata = new_byte;
   end

   // Pointer next values
   // Bit operations on pointers behave as on any other byte
   always_comb begin
      pointer_zero_d = pointer_zero_q;
      pointer_one_offset_d = pointer_one_offset_q;
      pointer_one_sector_d = pointer_one_sector_q;
      pointer_two_offset_d = pointer_two_offset_q;
      pointer_two_sector_d = pointer_two_sector_q;
      if (access && write && pointer_hit) begin
         case (eff_offset)
            `OFS_POINTER_ZERO: pointer_zero_d = new_byte;
            `OFS_POINTER_ONE_OFFSET: pointer_one_offset_d = new_byte;
            `OFS_POINTER_ONE_SECTOR: pointer_one_sector_d = new_byte;
            `OFS_POINTER_TWO_OFFSET: pointer_two_offset_d = new_byte;
            `OFS_POINTER_TWO_SECTOR: pointer_two_sector_d = new_byte;
            default: pointer_zero_d = pointer_zero_q;
         endcase
      end
   end

   // Pointer registers
   // Reset to 00H, so port zero starts out naming itself and reads as 00H
   always_ff @(posedge clock) begin
      if (rst) begin
         pointer_zero_q <= `POINTER_RESET;
         pointer_one_offset_q <= `POINTER_RESET;
         pointer_one_sector_q <= `POINTER_RESET;
         pointer_two_offset_q <= `POINTER_RESET;
         pointer_two_sector_q <= `POINTER_RESET;
      end else begin
         pointer_zero_q <= pointer_zero_d;
         pointer_one_offset_q <= pointer_one_offset_d;
         pointer_one_sector_q <= pointer_one_sector_d;
         pointer_two_offset_q <= pointer_two_offset_d;
         pointer_two_sector_q <= pointer_two_sector_d;
      end
   end

   // Display memory next values and the forwarding strobe to the driver
   // Only resolved display writes forward; reads never pulse the driver
   always_comb begin
      display_d = display_q;
      display_write_d = 1'b0;
      display_index_d = display_index_q;
      display_data_d = display_data_q;
      if (access && write && target == target_display_v) begin
         display_d[eff_offset[4:0]] = new_byte;
         display_write_d = 1'b1;
         display_index_d = eff_offset[4:0];
         display_data_d = new_byte;
      end
   end

   // Display memory; the driver sees each write one cycle later
   // Registered for a clean one-cycle strobe, traded against a cycle of latency
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < DISPLAY_DEPTH; i++) begin
            display_q[i] <= 8'h00;
         end
         display_write_q <= 1'b0;
         display_index_q <= 5'h00;
         display_data_q <= 8'h00;
      end else begin
         display_q <= display_d;
         display_write_q <= display_write_d;
         display_index_q <= display_index_d;
         display_data_q <= display_data_d;
      end
   end

   // Forwarding outputs come straight from flip-flops
   assign display_write = display_write_q;
   assign display_index = display_index_q;
   assign display_data = display_data_q;

   // General purpose storage with bit operations
   // Kept apart so its depth can change without touching the decoder
   general_purpose_store #(
      .DEPTH(GP_DEPTH)
   ) u_store (
      .clock(clock),
      .rst(rst),
      .res(res.store)
   );
endmodule : data_memory_sector_decoder
`default_nettype wire

// File: verif/sector_decoder_checker.sv
// Port-level assertions for the data memory sector decoder
`timescale 1ns/1ps
`default_nettype none
module sector_decoder_checker (
   input wire logic clock,
   input wire logic rst,
   input wire logic access,
   input wire logic write,
   input wire logic extended,
   input wire logic [10:0] address,
   input wire data_memory_sector_decoder_pkg::op_type op,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic sfr_select,
   input wire logic sfr_write,
   input wire logic sfr_read_only,
   input wire logic nonvolatile_control_select,
   input wire logic display_write,
   input wire logic [4:0] display_index,
   input wire logic [7:0] display_data
);
   import data_memory_sector_decoder_pkg::*;
   // All checks share the core clock and stay quiet in reset
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_nv_one;
      access && extended && address == 11'h140 |-> nonvolatile_control_select && !sfr_select;
   endproperty
   a_nv_one: assert property (p_nv_one) else $error("nv select missing");
   property p_nv_zero;
      access && !extended && address[7:0] == 8'h40 |-> !nonvolatile_control_select;
   endproperty
   a_nv_zero: assert property (p_nv_zero) else $error("nv seen in sector 0");
   property p_ro_write;
      sfr_write |-> access && write && !sfr_read_only;
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("bad sfr write");
   property p_unimpl;
      access && extended && address[10:8] == 3'h3 |-> rdata == 8'h00 && !sfr_write;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("sector 3 not empty");
   property p_unused;
      access && extended && address == 11'h141 |-> rdata == 8'h00 && !sfr_write;
   endproperty
   a_unused: assert property (p_unused) else $error("unused not zero");
   property p_display;
      access && write && extended && address[10:5] == 6'h20 && op == op_write_v |=>
         display_write && display_index == $past(address[4:0]) && display_data == $past(wdata);
   endproperty
   a_display: assert property (p_display) else $error("display not forwarded");
   property p_display_cause;
      display_write |-> $past(access && write);
   endproperty
   a_display_cause: assert property (p_display_cause) else $error("stray display");
   property p_gp_rw;
      access && write && extended && address == 11'h280 && op == op_write_v ##1
         access && !write && extended && address == 11'h280 |-> rdata == $past(wdata);
   endproperty
   a_gp_rw: assert property (p_gp_rw) else $error("general byte lost");
endmodule : sector_decoder_checker
`default_nettype wire

// File: verif/peripheral_model.sv
// Peripheral registers answering the special function window
`timescale 1ns/1ps
`default_nettype none
module peripheral_model #(
   parameter logic [7:0] RO_BASE = 8'h70
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic sfr_select,
   input wire logic sfr_write,
   input wire logic [7:0] sfr_offset,
   input wire logic [7:0] sfr_wdata,
   input wire logic nonvolatile_control_select,
   output logic [7:0] sfr_rdata,
   output logic sfr_read_only,
   output logic [7:0] nonvolatile_control_register
);
   logic [7:0] regs_q [0:127];
   // Upper offsets act as status registers; unselected bus shows inverted junk
   assign sfr_read_only = sfr_offset >= RO_BASE;
   assign sfr_rdata = sfr_select ? regs_q[sfr_offset[6:0]] : ~regs_q[sfr_offset[6:0]];
   // Register updates follow the write strobe alone, so a write that leaks
   // through to a read-only register shows up on the next readback
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < 128; i++) regs_q[i] <= 8'h00;
         nonvolatile_control_register <= 8'h00;
      end else if (sfr_write) begin
         if (nonvolatile_control_select) nonvolatile_control_register <= sfr_wdata;
         else if (sfr_select) regs_q[sfr_offset[6:0]] <= sfr_wdata;
      end
   end
endmodule : peripheral_model
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the data memory sector decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import data_memory_sector_decoder_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic access = 1'b0;
   logic write = 1'b0;
   logic extended = 1'b0;
   logic [10:0] address = 11'h000;
   op_type op = op_write_v;
   logic [2:0] bit_sel = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, sfr_offset, sfr_wdata, sfr_rdata, nonvolatile_control_register;
   logic sfr_select, sfr_write, sfr_read_only, nonvolatile_control_select, display_write;
   logic [4:0] display_index;
   logic [7:0] display_data, d;
   logic [10:0] a;
   logic [10:0] unused [5] = '{11'h141, 11'h300, 11'h420, 11'h580, 11'h7ff};
   op_type o;
   logic [2:0] b;
   int bad_count = 0;
   int n_compared = 0;
   always #5 clock = ~clock;
   data_memory_sector_decoder uut (.clock, .rst, .access, .write, .extended, .address, .op,
      .bit_sel, .wdata, .rdata, .sfr_select, .sfr_write, .sfr_offset, .sfr_wdata, .sfr_rdata,
      .sfr_read_only, .nonvolatile_control_select, .nonvolatile_control_register,
      .display_write, .display_index, .display_data);
   peripheral_model far_end (.clock, .rst, .sfr_select, .sfr_write, .sfr_offset, .sfr_wdata,
      .nonvolatile_control_select, .sfr_rdata, .sfr_read_only, .nonvolatile_control_register);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   // One core cycle; settles before the caller looks at read data
   task automatic acc(input logic w, input logic e, input logic [10:0] ad, input op_type p,
      input logic [2:0] bs, input logic [7:0] wd);
      @(posedge clock);
      access <= 1'b1;
      write <= w;
      extended <= e;
      address <= ad;
      op <= p;
      bit_sel <= bs;
      wdata <= wd;
      #1;
   endtask : acc
   task automatic wr(input logic e, input logic [10:0] ad, input logic [7:0] wd);
      acc(1'b1, e, ad, op_write_v, 3'h0, wd);
   endtask : wr
   task automatic rd(input logic e, input logic [10:0] ad, input logic [7:0] exp);
      acc(1'b0, e, ad, op_write_v, 3'h0, 8'h00);
      chk(rdata, exp);
   endtask : rd
   function automatic logic [7:0] bop(input logic [7:0] v, input op_type p, input logic [2:0] s);
      case (p)
         op_set_v: return v | (8'h01 << s);
         op_clear_v: return v & ~(8'h01 << s);
         default: return v;
      endcase
   endfunction : bop
   task automatic final_report;
      if (bad_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   // Main sequence: reset, random general bytes, then hand-picked corners
   initial begin
      void'($urandom(32'hbefd90d8));
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rd(1'b0, 11'h001, 8'h00);
      rd(1'b1, 11'h280, 8'h00);
      wr(1'b1, 11'h280, 8'hc3);
      rd(1'b1, 11'h280, 8'hc3);
      repeat (24) begin
         a = {3'($urandom % 3), 1'b1, 7'($urandom)};
         d = 8'($urandom);
         o = ($urandom % 2) ? op_set_v : op_clear_v;
         b = 3'($urandom);
         wr(1'b1, a, d);
         acc(1'b1, 1'b1, a, o, b, 8'h00);
         rd(1'b1, a, bop(d, o, b));
      end
      wr(1'b0, 11'h001, 8'h90);
      wr(1'b0, 11'h000, 8'h5a);
      rd(1'b1, 11'h090, 8'h5a);
      wr(1'b0, 11'h004, 8'h02);
      wr(1'b0, 11'h003, 8'ha0);
      wr(1'b0, 11'h002, 8'h3c);
      rd(1'b1, 11'h2a0, 8'h3c);
      wr(1'b0, 11'h00e, 8'h01);
      wr(1'b0, 11'h00d, 8'hf0);
      wr(1'b0, 11'h00c, 8'h81);
      rd(1'b1, 11'h1f0, 8'h81);
      rd(1'b0, 11'h00c, 8'h81);
      wr(1'b0, 11'h001, 8'h00);
      rd(1'b0, 11'h000, 8'h00);
      wr(1'b0, 11'h000, 8'hff);
      rd(1'b0, 11'h001, 8'h00);
      // Display byte through port one, then straight by extended address
      wr(1'b0, 11'h004, 8'h04);
      wr(1'b0, 11'h003, 8'h10);
      wr(1'b0, 11'h002, 8'haa);
      rd(1'b0, 11'h002, 8'haa);
      chk({7'h00, display_write}, 8'h01);
      chk({3'h0, display_index}, 8'h10);
      chk(display_data, 8'haa);
      wr(1'b1, 11'h41f, 8'h55);
      rd(1'b1, 11'h41f, 8'h55);
      foreach (unused[i]) begin
         wr(1'b1, unused[i], 8'h66);
         rd(1'b1, unused[i], 8'h00);
      end
      wr(1'b0, 11'h004, 8'h09);
      wr(1'b0, 11'h002, 8'h77);
      rd(1'b0, 11'h002, 8'h00);
      wr(1'b1, 11'h140, 8'h77);
      rd(1'b1, 11'h140, 8'h77);
      rd(1'b0, 11'h040, 8'h00);
      wr(1'b0, 11'h020, 8'h12);
      rd(1'b0, 11'h020, 8'h12);
      wr(1'b0, 11'h070, 8'h12);
      rd(1'b0, 11'h070, 8'h00);
      @(posedge clock);
      access <= 1'b0;
      final_report();
   end
   // Watchdog: the sequence needs about 140 cycles
   initial begin
      repeat (3000) @(posedge clock);
      bad_count++;
      final_report();
   end
endmodule : testbench
bind data_memory_sector_decoder sector_decoder_checker chk_i (.clock, .rst, .access, .write,
   .extended, .address, .op, .wdata, .rdata, .sfr_select, .sfr_write, .sfr_read_only,
   .nonvolatile_control_select, .display_write, .display_index, .display_data);
`default_nettype wire
